// ==== common/serial_two_wire_params.svh ====
// Offsets, field positions, reset values and the counter limit for the serial unit.
// Assumes inclusion by the design file only.
`ifndef SERIAL_TWO_WIRE_PARAMS_SVH
`define SERIAL_TWO_WIRE_PARAMS_SVH
`define REG_SHIFT_DATA    3'h0
`define REG_BYTE_BUFFER   3'h1
`define REG_FLAGS_COUNT   3'h2
`define REG_CONTROL       3'h3
`define REG_SYSTEM        3'h4
`define FLAG_START_BIT    7
`define FLAG_OVF_BIT      6
`define FLAG_STOP_BIT     5
`define FLAG_COLL_BIT     4
`define CTL_START_IE_BIT  7
`define CTL_OVF_IE_BIT    6
`define CTL_CLK_STROBE    1
`define CTL_PIN_TOGGLE    0
`define SYS_GLOBAL_IE     0
`define SYS_SLEEP_IDLE    1
`define SYS_SLEEP_DEEP    2
`define COUNT_MAX         4'hF
`define RESET_BYTE        8'h00
`endif

// ==== common/serial_two_wire_pkg.sv ====
// Types shared by the serial unit design.
// Assumes the params header is on the include path.
package serial_two_wire_pkg;
	typedef enum logic [1:0] {
		WM_OFF,
		WM_THREE,
		WM_TWO,
		WM_TWO_HOLD
	} wire_mode_t;
	typedef struct packed {
		logic sda_in;
		logic scl_in;
	} line_in_t;
	typedef struct packed {
		logic sda_oe;
		logic scl_oe;
		logic sda_pullup_en;
		logic scl_pullup_en;
	} line_out_t;
endpackage : serial_two_wire_pkg

// ==== design/universal_serial_two_wire.sv ====
// Universal serial unit, two-wire mode, with counter, shift register and flags.
// Assumes pins arrive asynchronously and are synchronised here; software on sys_clk.
//
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "serial_two_wire_params.svh"
module universal_serial_two_wire (
	input  wire logic                           sys_clk,
	input  wire logic                           reset,
	input  wire logic [2:0]                     addr,
	input  wire logic [7:0]                     wdata,
	input  wire logic                           wr,
	input  wire logic                           rd,
	output logic      [7:0]                     rdata,
	input  wire serial_two_wire_pkg::line_in_t  line_in,
	input  wire logic                           timer_match,
	input  wire logic                           sda_port_bit,
	input  wire logic                           scl_port_bit,
	input  wire logic                           sda_dir_out,
	input  wire logic                           scl_dir_out,
	output serial_two_wire_pkg::line_out_t      line_out,
	output logic                                start_irq,
	output logic                                overflow_irq,
	output logic                                wake
);
	import serial_two_wire_pkg::*;

	// ----------------------------------------
	// Registers and pin synchronisers
	// ----------------------------------------
	logic [7:0] shift_data;
	logic [7:0] byte_buffer;
	logic [3:0] edge_count;
	logic       start_cond_flag;
	logic       count_overflow_flag;
	logic       stop_cond_flag;
	logic       start_irq_enable;
	logic       overflow_irq_enable;
	wire_mode_t wire_mode_select;
	logic [1:0] clock_source_select;
	logic       global_ie;
	logic       sleep_idle;
	logic       sleep_deep;
	logic       out_latch;
	logic       start_hold;
	logic       ovf_hold;
	logic [1:0] sda_sync;
	logic [1:0] scl_sync;
	logic       sda_q;
	logic       scl_q;
	logic       serial_in_pin;
	logic       shift_clock_pin;

	assign serial_in_pin   = sda_sync[1];
	assign shift_clock_pin = scl_sync[1];

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			sda_sync <= 2'h3;
			scl_sync <= 2'h3;
			sda_q    <= 1'b1;
			scl_q    <= 1'b1;
		end else begin
			sda_sync <= {sda_sync[0], line_in.sda_in};
			scl_sync <= {scl_sync[0], line_in.scl_in};
			sda_q    <= serial_in_pin;
			scl_q    <= shift_clock_pin;
		end
	end

	// ----------------------------------------
	// Clock selection and decode
	// ----------------------------------------
	logic two_wire;
	logic scl_rise;
	logic scl_fall;
	logic ext_clk;
	logic pin_edge;
	logic sw_strobe;
	logic count_tick;
	logic shift_tick;
	logic wr_data;
	logic wr_flags;
	logic wr_ctl;
	logic start_seen;
	logic stop_seen;
	logic wrap;

	function automatic logic hit(input logic [2:0] a, input logic [2:0] r);
		hit = (a == r);
	endfunction : hit

	assign two_wire  = (wire_mode_select == WM_TWO) || (wire_mode_select == WM_TWO_HOLD);
	assign scl_rise  = shift_clock_pin && !scl_q;
	assign scl_fall  = !shift_clock_pin && scl_q;
	assign pin_edge  = scl_rise || scl_fall;
	assign ext_clk   = clock_source_select[1];
	assign wr_data   = wr && hit(addr, `REG_SHIFT_DATA);
	assign wr_flags  = wr && hit(addr, `REG_FLAGS_COUNT);
	assign wr_ctl    = wr && hit(addr, `REG_CONTROL);
	assign sw_strobe = wr_ctl && wdata[`CTL_CLK_STROBE];

	always_comb begin
		shift_tick = 1'b0;
		count_tick = 1'b0;
		case (clock_source_select)
			2'h0: begin
				shift_tick = sw_strobe;
				count_tick = sw_strobe;
			end
			2'h1: begin
				shift_tick = timer_match;
				count_tick = timer_match;
			end
			default: begin
				shift_tick = clock_source_select[0] ? scl_fall : scl_rise;
				count_tick = pin_edge || (sw_strobe && wdata[`CTL_PIN_TOGGLE]);
			end
		endcase
	end

	assign start_seen = two_wire && scl_q && shift_clock_pin && sda_q && !serial_in_pin;
	assign stop_seen  = two_wire && scl_q && shift_clock_pin && !sda_q && serial_in_pin;
	assign wrap       = count_tick && (edge_count == `COUNT_MAX);

	// ----------------------------------------
	// Shift register, counter and buffer
	// ----------------------------------------
	// write wins over shift
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			shift_data <= `RESET_BYTE;
		end else if (wr_data) begin
			shift_data <= wdata;
		end else if (shift_tick) begin
			shift_data <= {shift_data[6:0], serial_in_pin};
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			edge_count <= 4'h0;
		end else if (wr_flags) begin
			edge_count <= wdata[3:0];
		end else if (count_tick) begin
			edge_count <= edge_count + 4'h1;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			byte_buffer <= `RESET_BYTE;
		end else if (wrap) begin
			byte_buffer <= shift_tick ? {shift_data[6:0], serial_in_pin} : shift_data;
		end
	end

	// ----------------------------------------
	// Flags
	// ----------------------------------------
	// start sets flag
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			start_cond_flag <= 1'b0;
		end else if (start_seen || (!two_wire && ext_clk
			&& !(sw_strobe) && pin_edge && clock_source_select != 2'h1)) begin
			start_cond_flag <= 1'b1;
		end else if (wr_flags && wdata[`FLAG_START_BIT]) begin
			start_cond_flag <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			count_overflow_flag <= 1'b0;
		end else if (wrap) begin
			count_overflow_flag <= 1'b1;
		end else if (wr_flags && wdata[`FLAG_OVF_BIT]) begin
			count_overflow_flag <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			stop_cond_flag <= 1'b0;
		end else if (stop_seen) begin
			stop_cond_flag <= 1'b1;
		end else if (wr_flags && wdata[`FLAG_STOP_BIT]) begin
			stop_cond_flag <= 1'b0;
		end
	end

	// ----------------------------------------
	// Clock stretching
	// ----------------------------------------
	// hold after start fall
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			start_hold <= 1'b0;
		end else if (!two_wire || !start_cond_flag) begin
			start_hold <= 1'b0;
		end else if (scl_fall) begin
			start_hold <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			ovf_hold <= 1'b0;
		end else if (wire_mode_select != WM_TWO_HOLD) begin
			ovf_hold <= 1'b0;
		end else if (wrap) begin
			ovf_hold <= 1'b1;
		end else if (wr_flags && wdata[`FLAG_OVF_BIT]) begin
			ovf_hold <= 1'b0;
		end
	end

	// ----------------------------------------
	// Control and system registers
	// ----------------------------------------
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			start_irq_enable    <= 1'b0;
			overflow_irq_enable <= 1'b0;
			wire_mode_select    <= WM_OFF;
			clock_source_select <= 2'h0;
		end else if (wr_ctl) begin
			start_irq_enable    <= wdata[`CTL_START_IE_BIT];
			overflow_irq_enable <= wdata[`CTL_OVF_IE_BIT];
			wire_mode_select    <= wire_mode_t'(wdata[5:4]);
			clock_source_select <= wdata[3:2];
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			global_ie  <= 1'b0;
			sleep_idle <= 1'b0;
			sleep_deep <= 1'b0;
		end else if (wr && hit(addr, `REG_SYSTEM)) begin
			global_ie  <= wdata[`SYS_GLOBAL_IE];
			sleep_idle <= wdata[`SYS_SLEEP_IDLE];
			sleep_deep <= wdata[`SYS_SLEEP_DEEP];
		end
	end

	// ----------------------------------------
	// Output latch and pin drive
	// ----------------------------------------
	// latch open half cycle on external clock, always open on internal clock
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			out_latch <= 1'b1;
		end else if (!ext_clk || (clock_source_select[0] ? shift_clock_pin : !shift_clock_pin)) begin
			out_latch <= wr_data ? wdata[7] : shift_data[7];
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			line_out <= '{sda_oe: 1'b0, scl_oe: 1'b0, sda_pullup_en: 1'b1, scl_pullup_en: 1'b1};
		end else begin
			line_out.sda_oe <= (wire_mode_select != WM_OFF) && sda_dir_out
				&& (!out_latch || !sda_port_bit);
			line_out.scl_oe <= scl_dir_out && (!scl_port_bit || start_hold || ovf_hold);
			line_out.sda_pullup_en <= !two_wire;
			line_out.scl_pullup_en <= !two_wire;
		end
	end

	// ----------------------------------------
	// Interrupts, wake and read port
	// ----------------------------------------
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			start_irq    <= 1'b0;
			overflow_irq <= 1'b0;
			wake         <= 1'b0;
		end else begin
			start_irq    <= start_cond_flag && start_irq_enable && global_ie;
			overflow_irq <= count_overflow_flag && overflow_irq_enable && global_ie;
			wake <= (start_cond_flag && start_irq_enable && (sleep_idle || sleep_deep))
				|| (count_overflow_flag && overflow_irq_enable && sleep_idle);
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			rdata <= 8'h00;
		end else if (!rd) begin
			rdata <= 8'h00;
		end else if (hit(addr, `REG_SHIFT_DATA)) begin
			rdata <= shift_data;
		end else if (hit(addr, `REG_BYTE_BUFFER)) begin
			rdata <= byte_buffer;
		end else if (hit(addr, `REG_FLAGS_COUNT)) begin
			rdata <= {start_cond_flag, count_overflow_flag, stop_cond_flag,
				two_wire && (out_latch != serial_in_pin), edge_count};
		end else if (hit(addr, `REG_CONTROL)) begin
			rdata <= {start_irq_enable, overflow_irq_enable, wire_mode_select,
				clock_source_select, 2'h0};
		end else if (hit(addr, `REG_SYSTEM)) begin
			rdata <= {5'h00, sleep_deep, sleep_idle, global_ie};
		end else begin
			rdata <= 8'h00;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_start_fall;
		start_cond_flag && two_wire && scl_fall;
	endsequence

	a_start_flag_set: assert property (@(posedge sys_clk) disable iff (reset)
		start_seen |=> start_cond_flag) else $error("start not flagged");
	a_start_clear_one: assert property (@(posedge sys_clk) disable iff (reset)
		start_cond_flag && !start_seen && !pin_edge && !(wr_flags && wdata[7])
		|=> start_cond_flag) else $error("start flag lost");
	a_start_hold_scl: assert property (@(posedge sys_clk) disable iff (reset)
		s_start_fall ##1 (start_cond_flag && two_wire) |-> start_hold)
		else $error("no hold after start");
	a_wrap_ovf_flag: assert property (@(posedge sys_clk) disable iff (reset)
		wrap |=> count_overflow_flag) else $error("wrap missed");
	a_wrap_count_zero: assert property (@(posedge sys_clk) disable iff (reset)
		wrap && !wr_flags |=> edge_count == 4'h0) else $error("count not wrapped");
	a_write_beats_shift: assert property (@(posedge sys_clk) disable iff (reset)
		wr_data |=> shift_data == $past(wdata)) else $error("write lost");
	a_buffer_copy: assert property (@(posedge sys_clk) disable iff (reset)
		wrap && !shift_tick |=> byte_buffer == $past(shift_data)) else $error("buffer stale");
	a_detector_gated: assert property (@(posedge sys_clk) disable iff (reset)
		!two_wire |-> !start_seen ##1 !start_hold) else $error("detector active");
	a_ovf_hold_mode: assert property (@(posedge sys_clk) disable iff (reset)
		wrap && wire_mode_select == WM_TWO_HOLD && !(wr_flags && wdata[6]) |=> ##1
		line_out.scl_oe || !scl_dir_out) else $error("no overflow stretch");
	a_pullups_off: assert property (@(posedge sys_clk) disable iff (reset)
		two_wire |=> !line_out.sda_pullup_en) else $error("pull-up on");
endmodule : universal_serial_two_wire

// ==== verification/two_wire_master_model.sv ====
// Behavioural two-wire bus master for the serial unit.
// Assumes the bench resolves both open-drain lines with pull-ups.
`timescale 1ns/1ps
module two_wire_master_model (
	input  wire logic scl_line,
	input  wire logic sda_line,
	output logic      scl_low,
	output logic      sda_low
);
	int n_stall = 0;
	initial begin
		scl_low = 1'b0;
		sda_low = 1'b0;
	end
	task automatic start_cond();
		sda_low = 1'b1;
		#40;
		scl_low = 1'b1;
		#40;
	endtask : start_cond
	task automatic idle();
		sda_low = 1'b0;
		#40;
		scl_low = 1'b0;
		#80;
	endtask : idle
	task automatic clock_bit(input logic b, output logic s);
		int k;
		sda_low = ~b;
		#40;
		scl_low = 1'b0;
		for (k = 0; k < 500 && scl_line !== 1'b1; k++) #8;
		if (scl_line !== 1'b1) n_stall++;
		#40;
		s = sda_line;
		scl_low = 1'b1;
		#40;
	endtask : clock_bit
	task automatic send_byte(input logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) clock_bit(b[i], s);
	endtask : send_byte
endmodule : two_wire_master_model

// ==== verification/universal_serial_two_wire_tb.sv ====
// Self-checking bench for the two-wire serial unit.
// Assumes the package and the master model are compiled first.
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module universal_serial_two_wire_tb;
	import serial_two_wire_pkg::*;
	logic       sys_clk, reset, wr, rd, timer_match;
	logic [2:0] addr;
	logic [7:0] wdata, rdata, v;
	logic       sda_dir_out, scl_dir_out, scl_low, sda_low, scl, sda, sda_port_bit;
	logic       start_irq, overflow_irq, wake;
	line_in_t   line_in;
	line_out_t  line_out;
	int         n_errors = 0;
	int         n_checks = 0;
	assign scl = ~(scl_low | line_out.scl_oe);
	assign sda = ~(sda_low | line_out.sda_oe);
	assign line_in = {sda, scl};
	universal_serial_two_wire i_dut (
		.sys_clk(sys_clk), .reset(reset), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .line_in(line_in),
		.timer_match(timer_match), .sda_port_bit(sda_port_bit), .scl_port_bit(1'b1),
		.sda_dir_out(sda_dir_out), .scl_dir_out(scl_dir_out),
		.line_out(line_out), .start_irq(start_irq),
		.overflow_irq(overflow_irq), .wake(wake)
	);
	two_wire_master_model i_m (
		.scl_line(scl), .sda_line(sda), .scl_low(scl_low), .sda_low(sda_low)
	);
	// ------------------------------------------------------------
	// Bus tasks
	// ------------------------------------------------------------
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge sys_clk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [2:0] a);
		@(posedge sys_clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge sys_clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask : rd_reg
	task automatic wait_clk(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : wait_clk
	task automatic wrap_up();
		$display("checks=%0d errors=%0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : wrap_up
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		rd_reg(3'h2); `CHK(v, 8'h00) // reset value
		`CHK(line_out.scl_pullup_en, 1'b1)
		wr_reg(3'h6, 8'hFF);
		rd_reg(3'h6); `CHK(v, 8'h00)
		$display("reset test done");
	endtask : t_reset
	task automatic t_strobe();
		i_m.start_cond();
		wait_clk(6);
		rd_reg(3'h2); `CHK(v[7], 1'b0)
		i_m.idle();
		wr_reg(3'h0, 8'h81);
		wr_reg(3'h3, 8'h42);
		rd_reg(3'h0); `CHK(v, 8'h03)
		rd_reg(3'h2); `CHK(v & 8'hCF, 8'h01)
		wr_reg(3'h2, 8'h0F);
		wr_reg(3'h4, 8'h05);
		wr_reg(3'h3, 8'h42);
		wait_clk(2);
		rd_reg(3'h2); `CHK(v & 8'hCF, 8'h40)
		`CHK(overflow_irq, 1'b1)
		`CHK(wake, 1'b0)
		wr_reg(3'h4, 8'h03);
		wait_clk(2);
		`CHK(wake, 1'b1)
		wr_reg(3'h2, 8'h00);
		rd_reg(3'h2); `CHK(v & 8'hCF, 8'h40)
		wr_reg(3'h2, 8'h40);
		rd_reg(3'h2); `CHK(v & 8'hCF, 8'h00)
		$display("strobe test done");
	endtask : t_strobe
	task automatic t_timer();
		wr_reg(3'h3, 8'h04);
		wr_reg(3'h0, 8'h80);
		@(posedge sys_clk);
		timer_match <= 1'b1;
		@(posedge sys_clk);
		timer_match <= 1'b0;
		rd_reg(3'h0); `CHK(v, 8'h01)
		@(posedge sys_clk);
		addr        <= 3'h0;
		wdata       <= 8'h5A;
		wr          <= 1'b1;
		timer_match <= 1'b1;
		@(posedge sys_clk);
		wr          <= 1'b0;
		timer_match <= 1'b0;
		rd_reg(3'h0); `CHK(v, 8'h5A)
		$display("timer test done");
	endtask : t_timer
	task automatic t_three();
		wr_reg(3'h3, 8'h18);
		i_m.start_cond();
		wait_clk(6);
		rd_reg(3'h2); `CHK(v[7], 1'b1)
		i_m.idle();
		wr_reg(3'h2, 8'h00);
		rd_reg(3'h2); `CHK(v[7], 1'b1)
		wr_reg(3'h2, 8'h80);
		rd_reg(3'h2); `CHK(v[7], 1'b0)
		wr_reg(3'h3, 8'h1C);
		i_m.start_cond();
		i_m.idle();
		rd_reg(3'h2); `CHK(v[7], 1'b1)
		wr_reg(3'h2, 8'h80);
		$display("three-wire test done");
	endtask : t_three
	task automatic t_slave();
		logic s;
		wr_reg(3'h3, 8'h00);
		wr_reg(3'h0, 8'hFF);
		@(posedge sys_clk);
		sda_dir_out <= 1'b1;
		scl_dir_out <= 1'b1;
		wr_reg(3'h4, 8'h05);
		wr_reg(3'h3, 8'hB8);
		i_m.start_cond();
		wait_clk(6);
		rd_reg(3'h2); `CHK(v[7], 1'b1)
		`CHK(start_irq, 1'b1)
		`CHK(wake, 1'b1)
		`CHK(line_out.scl_oe, 1'b1)
		`CHK({line_out.sda_pullup_en, line_out.scl_pullup_en}, 2'b00)
		wr_reg(3'h2, 8'h80);
		wait_clk(2);
		`CHK(line_out.scl_oe, 1'b0)
		i_m.send_byte(8'hA5);
		wait_clk(4);
		rd_reg(3'h2); `CHK(v & 8'hCF, 8'h40)
		`CHK(line_out.scl_oe, 1'b1)
		rd_reg(3'h0); `CHK(v, 8'hA5)
		rd_reg(3'h1); `CHK(v, 8'hA5)
		wr_reg(3'h0, 8'h00);
		wait_clk(2);
		`CHK(line_out.sda_oe, 1'b1)
		wr_reg(3'h2, 8'h4E);
		i_m.clock_bit(1'b1, s);
		`CHK(s, 1'b0)
		wait_clk(4);
		rd_reg(3'h2); `CHK(v & 8'hCF, 8'h40)
		`CHK(line_out.scl_oe, 1'b1)
		wr_reg(3'h0, 8'hFF);
		wr_reg(3'h2, 8'h40);
		wait_clk(2);
		`CHK(line_out.scl_oe, 1'b0)
		wr_reg(3'h3, 8'hA8);
		wr_reg(3'h2, 8'h0F);
		i_m.clock_bit(1'b1, s);
		wait_clk(4);
		rd_reg(3'h2); `CHK(v & 8'hCF, 8'h41)
		`CHK(line_out.scl_oe, 1'b0)
		@(posedge sys_clk);
		sda_port_bit <= 1'b0;
		wait_clk(2);
		`CHK(line_out.sda_oe, 1'b1)
		@(posedge sys_clk);
		sda_port_bit <= 1'b1;
		wait_clk(2);
		`CHK(line_out.sda_oe, 1'b0)
		`CHK(i_m.n_stall, 0)
		$display("slave test done");
	endtask : t_slave
	// ------------------------------------------------------------
	// Main
	// ------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	initial begin
		#300000;
		n_errors++;
		$display("watchdog expired");
		wrap_up();
	end
	initial begin
		reset       = 1'b1;
		wr          = 1'b0;
		rd          = 1'b0;
		addr        = 3'h0;
		wdata       = 8'h00;
		timer_match = 1'b0;
		sda_dir_out = 1'b0;
		scl_dir_out = 1'b0;
		sda_port_bit = 1'b1;
		repeat (4) @(posedge sys_clk);
		reset <= 1'b0;
		t_reset();
		t_strobe();
		t_timer();
		t_three();
		t_slave();
		wrap_up();
	end
endmodule : universal_serial_two_wire_tb
